// ===== include/slot_init_pkg.sv
// constants and types for the slot control initial value register bank
// Contract
// - partition reset loads live fields from initial values when slot enable is set, else clears them to 0
// - bits 0-5 hold event and interrupt enables
// - attention indicator bits 7:6, default 0x3
// - power indicator bits 9:8, default 0x1
// - bit 10 power ctrl, bit 12 link change
package slot_init_pkg;
  localparam logic [11:0] init_values_offset = 12'h430;
  localparam logic [11:0] control_offset = 12'h434;
  localparam logic [11:0] live_offset = 12'h438;
  localparam logic [15:0] init_reset_value = 16'h01C0;
  localparam logic [15:0] init_writable_mask = 16'h17FF;
  localparam logic [15:0] live_reset_value = 16'h0000;
  localparam int attention_lsb = 6;
  localparam int power_ind_lsb = 8;
  localparam int power_ctrl_bit = 10;
  localparam int link_change_bit = 12;
  localparam int slot_enable_bit = 0;
  localparam int part_reset_bit = 1;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  typedef struct packed {
    logic [15:0] init_q;
    logic [15:0] live_q;
    logic slot_enable_q;
    logic awvalid_seen_q;
    logic [11:0] awaddr_q;
    logic wvalid_seen_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic load_done_q;
    logic awready_q;
    logic wready_q;
    logic arready_q;
  } state_t;
endpackage

// ===== hw/slot_init_regs.sv
// slot control initial value register bank on an axi4-lite slave
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module slot_init_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic part_reset_req,
  input wire logic [11:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [11:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic [15:0] live_slot_control,
  output logic slot_enable,
  output logic load_done
);
  slot_init_pkg::state_t s_q, s_d;

  function automatic logic [31:0] read_word(input logic [11:0] a,
      input slot_init_pkg::state_t s);
    read_word = 32'h0000_0000;
    if (a == slot_init_pkg::init_values_offset)
      read_word = {16'h0000, s.init_q};
    else if (a == slot_init_pkg::control_offset)
      read_word = {30'h0000_0000, s.load_done_q, s.slot_enable_q};
    else if (a == slot_init_pkg::live_offset)
      read_word = {16'h0000, s.live_q};
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == slot_init_pkg::init_values_offset) ||
      (a == slot_init_pkg::control_offset) ||
      (a == slot_init_pkg::live_offset);
  endfunction

  logic do_write;
  logic [15:0] merged;

  always_comb begin
    s_d = s_q;
    do_write = 1'b0;
    merged = s_q.init_q;
    if (s_awvalid && s_q.awready_q) begin
      s_d.awvalid_seen_q = 1'b1;
      s_d.awaddr_q = s_awaddr;
    end
    if (s_wvalid && s_q.wready_q) begin
      s_d.wvalid_seen_q = 1'b1;
      s_d.wdata_q = s_wdata;
      s_d.wstrb_q = s_wstrb;
    end
    if (s_q.awvalid_seen_q && s_q.wvalid_seen_q && !s_q.bvalid_q) begin
      do_write = 1'b1;
      s_d.awvalid_seen_q = 1'b0;
      s_d.wvalid_seen_q = 1'b0;
      s_d.bvalid_q = 1'b1;
      s_d.bresp_q = mapped(s_q.awaddr_q) ? slot_init_pkg::resp_okay :
        slot_init_pkg::resp_slverr;
    end
    if (s_q.bvalid_q && s_bready)
      s_d.bvalid_q = 1'b0;
    if (do_write && s_q.awaddr_q == slot_init_pkg::init_values_offset) begin
      if (s_q.wstrb_q[0])
        merged[7:0] = s_q.wdata_q[7:0];
      if (s_q.wstrb_q[1])
        merged[15:8] = s_q.wdata_q[15:8];
      // reserved bits 11 and 15:13 never store
      s_d.init_q = merged & slot_init_pkg::init_writable_mask;
    end
    if (do_write && s_q.awaddr_q == slot_init_pkg::control_offset &&
        s_q.wstrb_q[0])
      s_d.slot_enable_q = s_q.wdata_q[slot_init_pkg::slot_enable_bit];
    // software may also raise the reset through the control word
    if (part_reset_req || (do_write &&
        s_q.awaddr_q == slot_init_pkg::control_offset && s_q.wstrb_q[0] &&
        s_q.wdata_q[slot_init_pkg::part_reset_bit])) begin
      // only the live copy and load_done flag reset; initial values are retained
      s_d.load_done_q = 1'b0;
      if (s_q.slot_enable_q) begin
        s_d.live_q = s_q.init_q;
        s_d.load_done_q = 1'b1;
      end else begin
        s_d.live_q = slot_init_pkg::live_reset_value;
      end
    end
    if (s_arvalid && s_q.arready_q) begin
      s_d.rvalid_q = 1'b1;
      s_d.rdata_q = read_word(s_araddr, s_q);
      s_d.rresp_q = mapped(s_araddr) ? slot_init_pkg::resp_okay :
        slot_init_pkg::resp_slverr;
    end else if (s_q.rvalid_q && s_rready) begin
      s_d.rvalid_q = 1'b0;
    end
    // readies from the next state: accept only what the master saw offered
    s_d.awready_q = !s_d.awvalid_seen_q && !s_d.bvalid_q;
    s_d.wready_q = !s_d.wvalid_seen_q && !s_d.bvalid_q;
    s_d.arready_q = !s_d.rvalid_q;
  end

  // aresetn is the full device reset: the only reset that reloads init values (0x01C0)
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.init_q <= slot_init_pkg::init_reset_value;
      s_q.live_q <= slot_init_pkg::live_reset_value;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_awready = s_q.awready_q;
  assign s_wready = s_q.wready_q;
  assign s_arready = s_q.arready_q;
  assign s_bvalid = s_q.bvalid_q;
  assign s_bresp = s_q.bresp_q;
  assign s_rvalid = s_q.rvalid_q;
  assign s_rdata = s_q.rdata_q;
  assign s_rresp = s_q.rresp_q;
  assign live_slot_control = s_q.live_q;
  assign slot_enable = s_q.slot_enable_q;
  assign load_done = s_q.load_done_q;
endmodule
`default_nettype wire

// ===== testbench/slot_init_chk.sv
// slot init bank checker
`timescale 1ns/1ps
`default_nettype none
module slot_init_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic part_reset_req,
  input wire logic s_awready,
  input wire logic s_wready,
  input wire logic s_bvalid,
  input wire logic s_arready,
  input wire logic s_rvalid,
  input wire logic [15:0] live_slot_control,
  input wire logic slot_enable,
  input wire logic load_done
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_load; part_reset_req ##0 slot_enable; endsequence
  sequence s_nload; part_reset_req ##0 !slot_enable; endsequence
  property p_load; s_load |=> load_done; endproperty
  property p_skip; s_nload |=> live_slot_control == 16'h0000; endproperty
  property p_noload; s_nload |=> !load_done; endproperty
  property p_rsvd; (live_slot_control & 16'hE800) == 16'h0000; endproperty
  // live image moves only on a partition reset, pin or control write
  property p_stable;
    !$past(part_reset_req) && !$rose(s_bvalid) |->
      $stable(live_slot_control);
  endproperty
  property p_rrefuse; s_rvalid |-> !s_arready; endproperty
  property p_brefuse; s_bvalid |-> !s_awready && !s_wready; endproperty
  a_load: assert property (p_load) else $error("no load");
  a_skip: assert property (p_skip) else $error("live not cleared");
  a_noload: assert property (p_noload) else $error("load flag set");
  a_rsvd: assert property (p_rsvd) else $error("reserved live bit");
  a_stable: assert property (p_stable) else $error("live moved");
  a_rrefuse: assert property (p_rrefuse) else $error("read ready");
  a_brefuse: assert property (p_brefuse) else $error("write ready");
endmodule
bind slot_init_regs slot_init_chk u_chk (.*);
`default_nettype wire

// ===== testbench/test_slot_init_regs.sv
// slot init bank bench
`timescale 1ns/1ps
`default_nettype none
module test_slot_init_regs;
  logic aclk = 1'h0, aresetn = 1'h0, part_reset_req = 1'h0;
  logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_arvalid = 1'h0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic slot_enable, load_done, req_d = 1'h0;
  logic [1:0] s_bresp, s_rresp;
  logic [3:0] s_wstrb = 4'hF;
  logic [11:0] s_awaddr = 12'h0, s_araddr = 12'h0;
  logic [15:0] live_slot_control, m, p;
  logic [31:0] s_wdata = 32'h0, s_rdata, r;
  logic [33:0] er;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [17:0] lq[$];
  int errors = 0, samples_checked = 0;
  // ready lines tied high: every answer is taken at once
  slot_init_regs dut (.aclk, .aresetn, .part_reset_req, .s_awaddr,
    .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready(1'h1), .s_araddr, .s_arvalid,
    .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready(1'h1),
    .live_slot_control, .slot_enable, .load_done);
  initial forever #20 aclk = ~aclk;
  task chk_data(input logic [31:0] e, s);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("Error rdata exp %h got %h", e, s);
    end
  endtask
  task chk_resp(input string n, input logic [1:0] e, s);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("Error %s exp %h got %h", n, e, s);
    end
  endtask
  task chk_live(input logic [17:0] e, s);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("Error live exp %h got %h", e, s);
    end
  endtask
  // live outputs update on the edge that samples the reset request; checked one edge later
  always @(posedge aclk) begin
    if (s_rvalid) begin
      er = rq.pop_front();
      chk_data(er[31:0], s_rdata);
      chk_resp("rresp", er[33:32], s_rresp);
    end
    if (s_bvalid)
      chk_resp("bresp", bq.pop_front(), s_bresp);
    if (req_d)
      chk_live(lq.pop_front(),
        {slot_enable, load_done, live_slot_control});
    req_d <= part_reset_req;
  end
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st,
      input logic [1:0] e);
    logic aw_p, w_p;
    bq.push_back(e);
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= st;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    aw_p = 1'h1;
    w_p = 1'h1;
    while (aw_p || w_p) begin
      @(posedge aclk);
      if (aw_p && s_awready) begin
        s_awvalid <= 1'h0;
        aw_p = 1'h0;
      end
      if (w_p && s_wready) begin
        s_wvalid <= 1'h0;
        w_p = 1'h0;
      end
    end
    do @(posedge aclk); while (!s_bvalid);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    rq.push_back({e, d});
    {s_araddr, s_arvalid} <= {a, 1'h1};
    do @(posedge aclk); while (!s_arready);
    s_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_rvalid);
  endtask
  task pulse(input int n, input logic [17:0] e);
    repeat (n) lq.push_back(e);
    part_reset_req <= 1'h1;
    repeat (n) @(posedge aclk);
    part_reset_req <= 1'h0;
  endtask
  task wrap_up(input int e);
    errors += e;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial #40000 wrap_up(1);
  initial begin
    r = $urandom(90);
    m = r[15:0] & 16'h17FF;
    p = {r[15:8], ~r[7:0]} & 16'h17FF;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    pulse(1, 18'h0);
    wr(12'h434, 32'h1, 4'hF, 2'h0);
    pulse(2, {2'h3, 16'h01C0});
    rd(12'h438, 32'h1C0, 2'h0);
    rd(12'h430, 32'h1C0, 2'h0);
    wr(12'h430, r, 4'hF, 2'h0);
    rd(12'h430, {16'h0, m}, 2'h0);
    wr(12'h434, 32'h3, 4'hF, 2'h0);
    rd(12'h438, {16'h0, m}, 2'h0);
    wr(12'h430, ~r, 4'h1, 2'h0);
    rd(12'h430, {16'h0, p}, 2'h0);
    rd(12'h434, 32'h3, 2'h0);
    wr(12'h43C, 32'h0, 4'hF, 2'h2);
    rd(12'h43C, 32'h0, 2'h2);
    pulse(1, {2'h3, p});
    repeat (2) @(posedge aclk);
    errors += rq.size() + bq.size() + lq.size();
    wrap_up(0);
  end
endmodule
`default_nettype wire
